/* hdl/ips_pkg.sv */
// Constants and carrier types for the peripheral slave status and
// maintenance block. Assumes one 125 MHz clock domain.
package ips_pkg;

    localparam int AXI_AW = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CAPS = 8'h04;
    localparam logic [7:0] OFS_SLV = 8'h08;
    localparam logic [7:0] OFS_MADDR = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_SHIFT = 8'h14;

    // CTRL fields
    localparam int CTRL_DBL = 0;
    localparam int CTRL_STRM = 1;
    // CAPS fields
    localparam int CAP_SGL = 0;
    localparam int CAP_DBL = 1;
    localparam int CAP_IL = 2;
    localparam int CAP_STRM = 3;
    localparam int CAP_MM2 = 4;
    // Transfer settings octet fields
    localparam int TS_MM2 = 6;
    localparam int TS_DBL = 5;
    localparam int TS_STRM = 4;

    localparam logic [4:0] CAPS_RST = 5'h1f;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] SLV_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MM_IDLE,
        MM_MAINT,
        MM_RST
    } ips_mm_e;

    // Link side inputs, already decoded from the control lines
    typedef struct packed {
        logic maint;
        logic sync_out;
        logic resetsel1;
        logic [2:0] data_out;
        logic [2:0] enable_out;
        logic [2:0] clock_out;
        logic req_xfer;
        logic req_int;
        logic set_mode;
        logic set_dbl;
        logic set_strm;
    } ips_lnk_in_s;

    // Link side outputs
    typedef struct packed {
        logic [7:0] bus_b;
        logic bus_b_oe_n;
        logic drv_release;
        logic slave_reset;
        logic sel_reset_ok;
        logic mm2_selected;
    } ips_lnk_out_s;

endpackage

/* hdl/ips_top.sv */
// Slave status replies and maintenance logic with an AXI4-Lite
// register port. Link inputs are synchronous to aclk and already
// decoded into MAINT, RESETSEL1 and reply requests by the bus logic.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Overview of operation
// - Transfer settings bit 6 shows MM2 capability
// - Bit 5 shows current single or double octet
// - Bit 4 shows interlocked or streaming now
// - Bits 3 and 2 show streaming, interlocked ability
// - Bits 1 and 0 show double, single ability
// - Master commands switch supported current modes
// - Interrupt reply bit 6 busy, bit 5 ready
// - Bit 4 priority hold, bit 3 priority selected
// - Bits 2..0 pending class 3, 2, 1 interrupts
// - Bit 7 vendor use, no hardware effect
// - Maintenance logic can take over the drivers
// - Majority vote on levels of three lines
// - MAINT recognized releases every interface driver
// - MM1: data at sync fall resets, stays released
// - MM1: no data at sync fall restores drivers
// - No selective reset answer until RESETSEL1 frees
// - MM2 does MM1 work with data and enable
// - Matching shifted address selects, re-enables drivers
// - MM2 reset needs data and enable both
// - Enable falling ends frame, order becomes valid
// - Shift data on clock only while enable high
// - Shift regardless of earlier selection
module ips_top
    import ips_pkg::*;
#(
    parameter logic [4:0] CAPS_INIT = CAPS_RST,
    parameter logic [7:0] MADDR_INIT = 8'h00,
    parameter int SHIFT_W = 16
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Link
    input wire ips_lnk_in_s lnk_in,
    output ips_lnk_out_s lnk_out
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] ctrl;
        logic [4:0] caps;
        logic [7:0] slv;
        logic [7:0] maddr;
        ips_mm_e mm;
        logic locked;
        logic sync_q;
        logic clk_q;
        logic en_q;
        logic [SHIFT_W-1:0] shift;
        logic [SHIFT_W-1:0] frame;
        ips_lnk_out_s lo;
    } ips_state_s;

    ips_state_s st_reg;
    ips_state_s st_next;

    function automatic logic maj3(input logic [2:0] v);
        maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Voted maintenance signals

    logic v_data;
    logic v_en;
    logic v_clk;
    logic sync_fall;
    logic rst_hold;
    logic [7:0] tset;
    logic [31:0] rd_word;
    logic rd_ok;

    assign v_data = maj3(lnk_in.data_out);
    assign v_en = maj3(lnk_in.enable_out);
    assign v_clk = maj3(lnk_in.clock_out);
    assign sync_fall = st_reg.sync_q & ~lnk_in.sync_out;
    // An MM2 slave needs enable as well, so MM1-only masters
    // must drive both to reach it
    assign rst_hold = st_reg.caps[CAP_MM2] ? (v_data & v_en)
                                           : v_data;

    // Transfer settings octet
    always_comb begin
        tset = 8'h00;
        tset[TS_MM2] = st_reg.caps[CAP_MM2];
        tset[TS_DBL] = st_reg.ctrl[CTRL_DBL];
        tset[TS_STRM] = st_reg.ctrl[CTRL_STRM];
        tset[3:0] = st_reg.caps[3:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Register read mux

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (araddr)
            OFS_CTRL: rd_word[1:0] = st_reg.ctrl;
            OFS_CAPS: rd_word[4:0] = st_reg.caps;
            OFS_SLV: rd_word[7:0] = st_reg.slv;
            OFS_MADDR: rd_word[7:0] = st_reg.maddr;
            OFS_STAT: rd_word[5:0] = {st_reg.lo.sel_reset_ok,
                                      st_reg.lo.mm2_selected,
                                      st_reg.lo.slave_reset,
                                      st_reg.locked,
                                      st_reg.lo.drv_release,
                                      st_reg.mm == MM_MAINT};
            OFS_SHIFT: rd_word[SHIFT_W-1:0] = st_reg.frame;
            default: rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;
        st_next.sync_q = lnk_in.sync_out;
        st_next.clk_q = v_clk;
        st_next.en_q = v_en;

        // AXI write: address and data taken together, one at a time
        st_next.awready = 1'b0;
        st_next.wready = 1'b0;
        if (awvalid && wvalid && !st_reg.awready && !st_reg.bvalid) begin
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.awready && awvalid && wvalid) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (awaddr)
                OFS_CTRL: begin
                    // Only a supported width or method can be made current
                    if (wstrb[0] && (wdata[CTRL_DBL] ? st_reg.caps[CAP_DBL]
                            : st_reg.caps[CAP_SGL])) begin
                        st_next.ctrl[CTRL_DBL] = wdata[CTRL_DBL];
                    end
                    if (wstrb[0] && (wdata[CTRL_STRM] ? st_reg.caps[CAP_STRM]
                            : st_reg.caps[CAP_IL])) begin
                        st_next.ctrl[CTRL_STRM] = wdata[CTRL_STRM];
                    end
                end
                OFS_CAPS: if (wstrb[0]) st_next.caps = wdata[4:0];
                OFS_SLV: if (wstrb[0]) st_next.slv = wdata[7:0];
                OFS_MADDR: if (wstrb[0]) st_next.maddr = wdata[7:0];
                OFS_STAT, OFS_SHIFT: st_next.bresp = RESP_OKAY;
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end

        // AXI read
        st_next.arready = 1'b0;
        if (arvalid && !st_reg.arready && !st_reg.rvalid) begin
            st_next.arready = 1'b1;
        end
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
        if (st_reg.arready && arvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word;
            st_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // Mode change commanded by the master over the link
        if (lnk_in.set_mode) begin
            if (lnk_in.set_dbl ? st_reg.caps[CAP_DBL]
                    : st_reg.caps[CAP_SGL]) begin
                st_next.ctrl[CTRL_DBL] = lnk_in.set_dbl;
            end
            if (lnk_in.set_strm ? st_reg.caps[CAP_STRM]
                    : st_reg.caps[CAP_IL]) begin
                st_next.ctrl[CTRL_STRM] = lnk_in.set_strm;
            end
        end

        // Maintenance sequencing; MAINT comes only from a master
        // reset sequence, so it is trusted as decoded
        unique case (st_reg.mm)
            MM_IDLE: begin
                if (lnk_in.maint) begin
                    st_next.mm = MM_MAINT;
                    st_next.lo.drv_release = 1'b1;
                    st_next.lo.mm2_selected = 1'b0;
                end else if (st_reg.locked && lnk_in.resetsel1) begin
                    st_next.locked = 1'b0;
                    st_next.lo.drv_release = 1'b0;
                end
            end
            MM_MAINT: begin
                if (st_reg.caps[CAP_MM2] && v_en && v_clk
                        && !st_reg.clk_q) begin
                    // Loaded even when not selected
                    st_next.shift = {st_reg.shift[SHIFT_W-2:0],
                                     v_data};
                end
                if (st_reg.caps[CAP_MM2] && st_reg.en_q && !v_en) begin
                    st_next.frame = st_reg.shift;
                    if (st_reg.shift[7:0] == st_reg.maddr) begin
                        st_next.lo.mm2_selected = 1'b1;
                        st_next.lo.drv_release = 1'b0;
                    end
                end
                if (sync_fall || !lnk_in.maint) begin
                    if (sync_fall && rst_hold) begin
                        st_next.mm = MM_RST;
                        st_next.lo.slave_reset = 1'b1;
                        st_next.locked = 1'b1;
                        st_next.lo.drv_release = 1'b1;
                        st_next.lo.mm2_selected = 1'b0;
                    end else begin
                        st_next.mm = MM_IDLE;
                        st_next.lo.drv_release = 1'b0;
                    end
                end
            end
            MM_RST: begin
                if (!rst_hold) begin
                    // Drivers stay released until RESETSEL1
                    st_next.mm = MM_IDLE;
                    st_next.lo.slave_reset = 1'b0;
                end
                if (lnk_in.maint) begin
                    st_next.mm = MM_MAINT;
                    st_next.lo.slave_reset = 1'b0;
                end
            end
            default: st_next.mm = MM_IDLE;
        endcase

        st_next.lo.sel_reset_ok = ~st_next.locked;

        // Reply octets; released drivers never drive BUS B
        st_next.lo.bus_b = 8'h00;
        st_next.lo.bus_b_oe_n = 1'b1;
        if (!st_next.lo.drv_release) begin
            if (lnk_in.req_xfer) begin
                st_next.lo.bus_b = tset;
                st_next.lo.bus_b_oe_n = 1'b0;
            end else if (lnk_in.req_int) begin
                // Bit 7 is passed through and steers nothing here
                st_next.lo.bus_b = st_reg.slv;
                st_next.lo.bus_b_oe_n = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.mm <= MM_IDLE;
            st_reg.ctrl <= CTRL_RST;
            st_reg.caps <= CAPS_INIT;
            st_reg.slv <= SLV_RST;
            st_reg.maddr <= MADDR_INIT;
            st_reg.lo.bus_b_oe_n <= 1'b1;
            st_reg.lo.sel_reset_ok <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign awready = st_reg.awready;
    assign wready = st_reg.wready;
    assign bvalid = st_reg.bvalid;
    assign bresp = st_reg.bresp;
    assign arready = st_reg.arready;
    assign rvalid = st_reg.rvalid;
    assign rresp = st_reg.rresp;
    assign rdata = st_reg.rdata;
    assign lnk_out = st_reg.lo;

endmodule

/* sim/ips_top_assertions.sv */
// Link-side checks for ips_top, bound to every instance.
// Assumes one clock domain, synchronous active-low reset, ce high.
`timescale 1ns/1ps
module ips_top_chk
    import ips_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link
    input wire ips_lnk_in_s lnk_in,
    input wire ips_lnk_out_s lnk_out
);
    logic vd;
    logic ve;
    function automatic logic maj(input logic [2:0] v);
        return (v[0] & v[1]) | (v[2] & (v[0] | v[1]));
    endfunction
    // Votes on levels, so one broken wire cannot fake a command
    assign vd = maj(lnk_in.data_out);
    assign ve = maj(lnk_in.enable_out);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    property p_no_drive;
        lnk_out.drv_release |-> lnk_out.bus_b_oe_n;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("bus_b driven while released");
    property p_maint_rel;
        $rose(lnk_in.maint) |=> lnk_out.drv_release;
    endproperty
    a_maint_rel: assert property (p_maint_rel)
        else $error("drivers kept after maint");
    property p_reply;
        !lnk_out.bus_b_oe_n |-> $past(lnk_in.req_xfer | lnk_in.req_int);
    endproperty
    a_reply: assert property (p_reply)
        else $error("bus_b driven without request");
    property p_ts_top;
        $past(lnk_in.req_xfer) && !lnk_out.bus_b_oe_n |-> !lnk_out.bus_b[7];
    endproperty
    a_ts_top: assert property (p_ts_top)
        else $error("settings octet bit 7 set");
    property p_rst_cause;
        lnk_out.slave_reset |-> $past(vd);
    endproperty
    a_rst_cause: assert property (p_rst_cause)
        else $error("reset without voted data");
    property p_rst_drop;
        lnk_out.slave_reset && !vd |=> !lnk_out.slave_reset;
    endproperty
    a_rst_drop: assert property (p_rst_drop)
        else $error("reset outlived data");
    property p_rst_rel;
        lnk_out.slave_reset |-> lnk_out.drv_release && !lnk_out.sel_reset_ok;
    endproperty
    a_rst_rel: assert property (p_rst_rel)
        else $error("reset with drivers back");
    property p_no_rst;
        $fell(lnk_in.sync_out) && lnk_in.maint && $past(lnk_in.maint) && !vd
            |=> !lnk_out.slave_reset && !lnk_out.drv_release;
    endproperty
    a_no_rst: assert property (p_no_rst)
        else $error("idle data still gave reset");
    property p_sel;
        $rose(lnk_out.mm2_selected)
            |-> $past(ve, 2) && !$past(ve) && !lnk_out.drv_release;
    endproperty
    a_sel: assert property (p_sel)
        else $error("selection off frame end");
    property p_sel_ok;
        $rose(lnk_out.sel_reset_ok) |-> $past(lnk_in.resetsel1);
    endproperty
    a_sel_ok: assert property (p_sel_ok)
        else $error("answer freed without resetsel1");
endmodule

bind ips_top ips_top_chk chk (.aclk(aclk), .aresetn(aresetn),
    .lnk_in(lnk_in), .lnk_out(lnk_out));

/* sim/ips_master_model.sv */
// Bus master model: drives the decoded link control lines.
// Tasks start and end just after a rising edge of aclk.
`timescale 1ns/1ps
module ips_master_model
    import ips_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Link
    output ips_lnk_in_s lnk
);
    initial lnk = '0;
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic maint_on();
        lnk.maint <= 1'b1;
        lnk.sync_out <= 1'b1;
        tick(2);
    endtask
    task automatic lines(input logic [2:0] d, e);
        lnk.data_out <= d;
        lnk.enable_out <= e;
        tick(1);
    endtask
    // Data and enable are set before sync drops
    task automatic sync_drop();
        lnk.sync_out <= 1'b0;
        tick(1);
        lnk.maint <= 1'b0;
        tick(2);
    endtask
    // Sent MSB first; line 1 of data and line 2 of clock are faulty
    task automatic frame(input logic [15:0] w);
        lines(3'b111, 3'b000);
        lnk.clock_out <= 3'b111;
        tick(1);
        lnk.clock_out <= 3'b000;
        lines(3'b000, 3'b111);
        for (int i = 15; i >= 0; i--) begin
            lnk.data_out <= {w[i], ~w[i], w[i]};
            tick(1);
            lnk.clock_out <= 3'b011;
            tick(1);
            lnk.clock_out <= 3'b000;
            tick(1);
        end
        lines(3'b000, 3'b000);
        tick(2);
    endtask
endmodule

/* sim/ips_top_bench.sv */
// Self-checking bench for ips_top: AXI4-Lite tasks, link model.
// Assumes the checker is bound in; ce is high except during the frozen-reply check.
`timescale 1ns/1ps
module ips_top_bench
    import ips_pkg::*;
;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    ips_lnk_in_s lnk_in;
    ips_lnk_out_s lnk_out;
    int mismatches = 0, comparisons = 0;
    // Caps, control, expected settings octet
    localparam logic [23:0] TS [7] = '{24'h1f037f, 24'h1f025f,
        24'h1f016f, 24'h1f004f, 24'h050305, 24'h0a033a, 24'h0f012f};
    always #4 aclk = ~aclk;
    ips_master_model mdl (.aclk(aclk), .lnk(lnk_in));
    ips_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .lnk_in(lnk_in), .lnk_out(lnk_out));
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic lim(input int n);
        if (n >= 40) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        lim(n);
        check("bresp", 32'(bresp), a > 8'h14 ? 32'h2 : 32'h0);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        lim(n);
        check("rdata", rdata, e);
        check("rresp", 32'(rresp), a > 8'h14 ? 32'h2 : 32'h0);
        @(posedge aclk);
    endtask
    task automatic reply(input logic x, i, oe, input logic [7:0] e);
        mdl.lnk.req_xfer <= x;
        mdl.lnk.req_int <= i;
        @(posedge aclk);
        #1;
        check("oe_n", 32'(lnk_out.bus_b_oe_n), 32'(oe));
        if (!oe)
            check("bus_b", 32'(lnk_out.bus_b), 32'(e));
        @(posedge aclk);
        mdl.lnk.req_xfer <= 1'b0;
        mdl.lnk.req_int <= 1'b0;
        @(posedge aclk);
    endtask
    // Release, reset, answer-allowed, selected
    task automatic outs(input logic [3:0] e);
        check("link", 32'({lnk_out.drv_release, lnk_out.slave_reset,
            lnk_out.sel_reset_ok, lnk_out.mm2_selected}), 32'(e));
    endtask
    task automatic resel();
        mdl.lnk.resetsel1 <= 1'b1;
        mdl.tick(2);
        mdl.lnk.resetsel1 <= 1'b0;
        mdl.tick(1);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_CAPS, 32'h1f);
        rd(OFS_STAT, 32'h20);
        rd(8'h18, 32'h0);
        wr(8'h18, 32'h1);
        wr(OFS_SHIFT, 32'hffff);
        for (int k = 0; k < 7; k++) begin
            wr(OFS_CAPS, 32'(TS[k][23:16]));
            wr(OFS_CTRL, 32'(TS[k][15:8]));
            reply(1, 0, 0, TS[k][7:0]);
        end
        mdl.lnk.set_mode <= 1'b1;
        mdl.lnk.set_strm <= 1'b1;
        mdl.tick(1);
        mdl.lnk.set_mode <= 1'b0;
        reply(1, 1, 0, 8'h1f);
        for (int k = 0; k < 9; k++) begin
            wr(OFS_SLV, k < 8 ? 32'h1 << k : 32'ha5);
            reply(0, 1, 0, k < 8 ? 8'h1 << k : 8'ha5);
        end
        // Only byte lane 0 carries the octet
        wstrb <= 4'he;
        wr(OFS_SLV, 32'h3c);
        wstrb <= 4'hf;
        reply(0, 1, 0, 8'ha5);
        // Clock enable low must hold the reply back
        ce <= 1'b0;
        mdl.lnk.req_int <= 1'b1;
        mdl.tick(2);
        check("frozen_oe_n", 32'(lnk_out.bus_b_oe_n), 32'h1);
        ce <= 1'b1;
        mdl.tick(1);
        #1;
        check("thawed_oe_n", 32'(lnk_out.bus_b_oe_n), 32'h0);
        check("thawed_bus_b", 32'(lnk_out.bus_b), 32'ha5);
        mdl.lnk.req_int <= 1'b0;
        mdl.tick(2);
        mdl.maint_on();
        reply(0, 1, 1, 8'h0);
        mdl.lines(3'b011, 3'b000);
        mdl.sync_drop();
        outs(4'b1100);
        mdl.lines(3'b001, 3'b000);
        mdl.tick(2);
        outs(4'b1000);
        resel();
        outs(4'b0010);
        mdl.maint_on();
        mdl.lines(3'b100, 3'b111);
        mdl.sync_drop();
        outs(4'b0010);
        wr(OFS_CAPS, 32'h1f);
        wr(OFS_MADDR, 32'h5a);
        mdl.maint_on();
        mdl.lines(3'b111, 3'b000);
        mdl.sync_drop();
        outs(4'b0010);
        mdl.maint_on();
        mdl.lines(3'b110, 3'b011);
        mdl.sync_drop();
        outs(4'b1100);
        mdl.lines(3'b111, 3'b000);
        mdl.tick(2);
        outs(4'b1000);
        mdl.lines(3'b000, 3'b000);
        resel();
        mdl.maint_on();
        mdl.frame(16'hc35a);
        outs(4'b0011);
        rd(OFS_SHIFT, 32'hc35a);
        mdl.frame(16'h3c5a);
        rd(OFS_SHIFT, 32'h3c5a);
        mdl.sync_drop();
        tally_and_finish();
    end
endmodule
